// ===== logic/tefl_top.sv
// Telemetry extremes trackers, sense voltage readout and fault log control
`timescale 1ns/10ps
module tefl_top #(
  parameter int NCH = 4
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Decoded send-byte commands
  input  wire logic              cmd_valid,
  input  wire logic [7:0]        cmd_code,
  // Word and byte reads
  input  wire logic              rd_req,
  input  wire logic [7:0]        rd_code,
  input  wire logic [1:0]        rd_page,
  output logic      [15:0]       rd_data,
  output logic                   rd_ack,
  output logic                   rd_err,
  // Log block read
  input  wire logic              blk_start,
  input  wire logic              blk_next,
  input  wire logic              blk_done,
  output logic      [7:0]        blk_data,
  output logic                   blk_ack,
  output logic                   blk_last,
  // ADC results and system state
  input  wire logic              adc_valid,
  input  wire logic [2:0]        adc_kind,
  input  wire logic [1:0]        adc_chan,
  input  wire logic [15:0]       adc_data,
  input  wire logic [NCH-1:0]    margin_low_ignore,
  input  wire logic              fault_off,
  input  wire logic [40:0]       share_time,
  input  wire logic [NCH*24-1:0] chan_status,
  // Non-volatile memory port
  output logic                   nvm_req,
  output logic                   nvm_we,
  output logic      [7:0]        nvm_addr,
  output logic      [7:0]        nvm_wdata,
  input  wire logic              nvm_ack,
  input  wire logic [7:0]        nvm_rdata,
  // Status
  output logic      [7:0]        log_status,
  output logic                   busy
);

  typedef enum logic [2:0] {
    TEFL_BOOT    = 3'h0,
    TEFL_IDLE    = 3'h1,
    TEFL_STORE   = 3'h2,
    TEFL_RESTORE = 3'h3,
    TEFL_ERASE   = 3'h4
  } tefl_fsm_t;

  typedef struct packed {
    tefl_fsm_t                state;
    logic [7:0]               addr;
    logic                     stat_eeprom;
    logic                     stat_ram;
    logic                     pend_store;
    logic                     pend_restore;
    logic                     pend_clear;
    logic [7:0]               pos;
    logic [6:0]               ref_idx;
    logic                     hi_pend;
    logic [7:0]               hi_byte;
    logic [7:0]               blk_idx;
    logic [15:0]              rd_data;
    logic                     rd_ack;
    logic                     rd_err;
    logic [7:0]               blk_data;
    logic                     blk_ack;
    logic                     blk_last;
    logic                     nvm_req;
    logic                     nvm_we;
    logic [7:0]               nvm_addr;
    logic [7:0]               nvm_wdata;
    logic [NCH-1:0][15:0]     sense;
  } tefl_state_t;

  tefl_state_t st_reg;
  tefl_state_t st_next;

  logic [7:0]           log_mem [0:255];
  logic                 mem_we;
  logic [7:0]           mem_waddr;
  logic [7:0]           mem_wdata;
  logic                 trk_clear;
  logic                 upd_vin;
  logic [NCH-1:0]       upd_vout;
  logic [NCH-1:0]       upd_iout;
  logic [NCH-1:0]       upd_temp;
  logic [15:0]          vin_peak;
  logic [15:0]          vin_min;
  logic [NCH-1:0][15:0] vout_peak;
  logic [NCH-1:0][15:0] vout_min;
  logic [NCH-1:0][15:0] iout_peak;
  logic [NCH-1:0][15:0] iout_min;
  logic [NCH-1:0][15:0] temp_peak;
  logic [NCH-1:0][15:0] temp_min;
  logic [25:0][15:0]    pre_words;
  logic [7:0]           pre_byte;
  logic [15:0]          sense_mag;
  logic                 log_locked;

  // Tracker clear strobe from the command stream, update strobe from the ADC result stream
  assign trk_clear = cmd_valid && (cmd_code == tefl_pkg::CMD_CLEAR_FAULTS);
  assign upd_vin   = adc_valid && (adc_kind == tefl_pkg::TEFL_ADC_VIN);

  // One set of trackers per channel
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++)
    begin : g_chan
      assign upd_vout[ch] = adc_valid && (adc_kind == tefl_pkg::TEFL_ADC_VOUT)
                            && (adc_chan == 2'(ch));
      assign upd_iout[ch] = adc_valid && (adc_kind == tefl_pkg::TEFL_ADC_IOUT)
                            && (adc_chan == 2'(ch));
      assign upd_temp[ch] = adc_valid && (adc_kind == tefl_pkg::TEFL_ADC_TEMP1)
                            && (adc_chan == 2'(ch));

      // Output voltage, unsigned linear format
      tefl_tracker #(
        .IS_L11   (1'b0),
        .RST_PEAK (tefl_pkg::RST_VOUT_PEAK),
        .RST_MIN  (tefl_pkg::RST_VOUT_MIN)
      ) u_vout (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .clear      (trk_clear),
        .upd        (upd_vout[ch]),
        .min_freeze (margin_low_ignore[ch]), // RULE_08
        .value      (adc_data),
        .peak       (vout_peak[ch]), // RULE_03
        .min        (vout_min[ch])   // RULE_07
      );

      // Output current
      tefl_tracker #(
        .IS_L11   (1'b1),
        .RST_PEAK (tefl_pkg::RST_L11_PEAK),
        .RST_MIN  (tefl_pkg::RST_L11_MIN)
      ) u_iout (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .clear      (trk_clear),
        .upd        (upd_iout[ch]),
        .min_freeze (1'b0),
        .value      (adc_data),
        .peak       (iout_peak[ch]), // RULE_04
        .min        (iout_min[ch])   // RULE_09
      );

      // External diode temperature
      tefl_tracker #(
        .IS_L11   (1'b1),
        .RST_PEAK (tefl_pkg::RST_L11_PEAK),
        .RST_MIN  (tefl_pkg::RST_L11_MIN)
      ) u_temp (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .clear      (trk_clear),
        .upd        (upd_temp[ch]),
        .min_freeze (1'b0),
        .value      (adc_data),
        .peak       (temp_peak[ch]), // RULE_05
        .min        (temp_min[ch])   // RULE_10
      );
    end
  endgenerate

  // Input voltage trackers
  tefl_tracker #(
    .IS_L11   (1'b1),
    .RST_PEAK (tefl_pkg::RST_L11_PEAK),
    .RST_MIN  (tefl_pkg::RST_L11_MIN)
  ) u_vin (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .clear      (trk_clear),
    .upd        (upd_vin),
    .min_freeze (1'b0),
    .value      (adc_data),
    .peak       (vin_peak), // RULE_02
    .min        (vin_min)   // RULE_06
  );

  // Magnitude of the raw sense conversion
  assign sense_mag = adc_data[15] ? 16'(-adc_data) : adc_data; // RULE_01

  // Preamble word order: channel 0, input, then channels 1 to 3
  always_comb
  begin
    pre_words = '0;
    for (int c = 0; c < NCH; c++)
    begin
      pre_words[(c == 0) ? 0 : c * 6 + 2 + 0] = vout_peak[c];
      pre_words[(c == 0) ? 1 : c * 6 + 2 + 1] = vout_min[c];
      pre_words[(c == 0) ? 2 : c * 6 + 2 + 2] = temp_peak[c];
      pre_words[(c == 0) ? 3 : c * 6 + 2 + 3] = temp_min[c];
      pre_words[(c == 0) ? 4 : c * 6 + 2 + 4] = iout_peak[c];
      pre_words[(c == 0) ? 5 : c * 6 + 2 + 5] = iout_min[c];
    end
    pre_words[6] = vin_peak;
    pre_words[7] = vin_min;
  end

  // Preamble byte for the refresh walker
  always_comb
  begin
    logic [6:0] off;
    off = 7'h00;
    if (st_reg.ref_idx == 7'h00)
      pre_byte = st_reg.pos;
    else if (st_reg.ref_idx < tefl_pkg::PRE_WORD_BYTE)
    begin
      off      = st_reg.ref_idx - tefl_pkg::PRE_TIME_BYTE;
      pre_byte = 8'(share_time >> (int'(off) * 8));
    end
    else if (st_reg.ref_idx < tefl_pkg::PRE_STAT_BYTE)
    begin
      off      = st_reg.ref_idx - tefl_pkg::PRE_WORD_BYTE;
      pre_byte = off[0] ? pre_words[off[6:1]][15:8] : pre_words[off[6:1]][7:0];
    end
    else
    begin
      off      = st_reg.ref_idx - tefl_pkg::PRE_STAT_BYTE;
      pre_byte = chan_status[int'(off) * 8 +: 8];
    end
  end

  assign log_locked = st_reg.stat_ram; // RULE_18

  // Next-state logic: command handling, log sequencing and reads
  always_comb
  begin
    st_next         = st_reg;
    st_next.rd_ack  = 1'b0;
    st_next.blk_ack = 1'b0;
    mem_we          = 1'b0;
    mem_waddr       = 8'h00;
    mem_wdata       = 8'h00;

    // Send-byte commands are queued until the sequencer is free
    if (cmd_valid && cmd_code == tefl_pkg::CMD_LOG_STORE)
      st_next.pend_store = 1'b1; // RULE_12
    if (fault_off)
      st_next.pend_store = 1'b1; // RULE_13
    if (cmd_valid && cmd_code == tefl_pkg::CMD_LOG_RESTORE)
      st_next.pend_restore = 1'b1; // RULE_14
    if (cmd_valid && cmd_code == tefl_pkg::CMD_LOG_CLEAR)
      st_next.pend_clear = 1'b1; // RULE_15

    // Sense voltage capture
    if (adc_valid && adc_kind == tefl_pkg::TEFL_ADC_SENSE)
      st_next.sense[adc_chan] = sense_mag; // RULE_01

    // Continuous log refresh outside boot and restore while the RAM is not locked
    if (st_reg.state != TEFL_BOOT && st_reg.state != TEFL_RESTORE)
    begin
      if (log_locked)
        st_next.hi_pend = 1'b0;
      else if (st_reg.hi_pend)
      begin
        mem_we          = 1'b1; // RULE_11
        mem_waddr       = tefl_pkg::LOOP_BASE + st_reg.pos;
        mem_wdata       = st_reg.hi_byte;
        st_next.hi_pend = 1'b0;
        st_next.pos     = (st_reg.pos == tefl_pkg::LOOP_LAST_POS) ? 8'h00 : st_reg.pos + 8'h01;
      end
      else if (adc_valid && adc_kind != tefl_pkg::TEFL_ADC_SENSE)
      begin
        mem_we          = 1'b1; // RULE_11
        mem_waddr       = tefl_pkg::LOOP_BASE + st_reg.pos;
        mem_wdata       = adc_data[7:0];
        st_next.hi_pend = 1'b1;
        st_next.hi_byte = adc_data[15:8];
        st_next.pos     = (st_reg.pos == tefl_pkg::LOOP_LAST_POS) ? 8'h00 : st_reg.pos + 8'h01;
      end
      else
      begin
        mem_we          = 1'b1; // RULE_11
        mem_waddr       = {1'b0, st_reg.ref_idx};
        mem_wdata       = pre_byte;
        st_next.ref_idx = (st_reg.ref_idx == tefl_pkg::PRE_LAST_BYTE) ? 7'h00
                          : st_reg.ref_idx + 7'h01;
      end
    end

    // Sequencer over the non-volatile memory port
    case (st_reg.state)
      TEFL_BOOT:
      begin
        st_next.nvm_req  = 1'b1;
        st_next.nvm_we   = 1'b0;
        st_next.nvm_addr = tefl_pkg::NVM_FLAG_ADDR;
        if (nvm_ack && st_reg.nvm_req)
        begin
          st_next.stat_eeprom = nvm_rdata[0]; // RULE_22
          st_next.nvm_req     = 1'b0;
          st_next.state       = TEFL_IDLE;
        end
      end
      TEFL_IDLE:
      begin
        st_next.addr = 8'h00;
        if (st_reg.pend_clear)
        begin
          st_next.pend_clear = 1'b0;
          st_next.state      = TEFL_ERASE; // RULE_15
        end
        else if (st_reg.pend_restore)
        begin
          st_next.pend_restore = 1'b0;
          st_next.state        = TEFL_RESTORE; // RULE_14
        end
        else if (st_reg.pend_store)
        begin
          st_next.pend_store = 1'b0;
          if (!st_reg.stat_eeprom) // RULE_17
            st_next.state = TEFL_STORE;
        end
      end
      TEFL_STORE:
      begin
        st_next.nvm_req   = 1'b1;
        st_next.nvm_we    = 1'b1;
        st_next.nvm_addr  = st_reg.addr;
        st_next.nvm_wdata = (st_reg.addr == tefl_pkg::NVM_FLAG_ADDR) ? tefl_pkg::NVM_FLAG_SET
                            : log_mem[st_reg.addr];
        if (nvm_ack && st_reg.nvm_req)
        begin
          st_next.nvm_req = 1'b0;
          st_next.addr    = st_reg.addr + 8'h01;
          if (st_reg.addr == tefl_pkg::NVM_FLAG_ADDR)
          begin
            st_next.stat_eeprom = 1'b1; // RULE_17
            st_next.state       = TEFL_IDLE;
          end
        end
      end
      TEFL_RESTORE:
      begin
        st_next.nvm_req  = 1'b1;
        st_next.nvm_we   = 1'b0;
        st_next.nvm_addr = st_reg.addr;
        if (nvm_ack && st_reg.nvm_req)
        begin
          mem_we          = 1'b1; // RULE_14
          mem_waddr       = st_reg.addr;
          mem_wdata       = nvm_rdata;
          st_next.nvm_req = 1'b0;
          st_next.addr    = st_reg.addr + 8'h01;
          if (st_reg.addr == tefl_pkg::LOG_LAST_BYTE)
          begin
            st_next.stat_ram = 1'b1; // RULE_18
            st_next.state    = TEFL_IDLE;
          end
        end
      end
      TEFL_ERASE:
      begin
        st_next.nvm_req   = 1'b1;
        st_next.nvm_we    = 1'b1;
        st_next.nvm_addr  = st_reg.addr;
        st_next.nvm_wdata = tefl_pkg::NVM_ERASED;
        if (nvm_ack && st_reg.nvm_req)
        begin
          st_next.nvm_req = 1'b0;
          st_next.addr    = st_reg.addr + 8'h01;
          if (st_reg.addr == tefl_pkg::NVM_FLAG_ADDR)
          begin
            st_next.stat_eeprom = 1'b0; // RULE_15
            st_next.state       = TEFL_IDLE;
          end
        end
      end
      default:
        st_next.state = TEFL_IDLE;
    endcase

    // A completed block read unlocks the RAM; a finishing restore wins
    if (blk_done && !(st_reg.state == TEFL_RESTORE && st_next.state == TEFL_IDLE))
      st_next.stat_ram = 1'b0; // RULE_18

    // Word and byte reads, all unpaged except the per-channel ones
    if (rd_req)
    begin
      st_next.rd_ack  = 1'b1;
      st_next.rd_err  = 1'b0;
      st_next.rd_data = 16'h0000;
      case (rd_code)
        tefl_pkg::CMD_LOG_STATUS:
          st_next.rd_data = {8'h00, 6'h00, st_reg.stat_ram, st_reg.stat_eeprom}; // RULE_21
        tefl_pkg::CMD_SENSE_VOLTAGE: st_next.rd_data = st_reg.sense[rd_page]; // RULE_01
        tefl_pkg::CMD_VIN_PEAK:      st_next.rd_data = vin_peak;
        tefl_pkg::CMD_VIN_MIN:       st_next.rd_data = vin_min;
        tefl_pkg::CMD_VOUT_PEAK:     st_next.rd_data = vout_peak[rd_page];
        tefl_pkg::CMD_VOUT_MIN:      st_next.rd_data = vout_min[rd_page];
        tefl_pkg::CMD_IOUT_PEAK:     st_next.rd_data = iout_peak[rd_page];
        tefl_pkg::CMD_IOUT_MIN:      st_next.rd_data = iout_min[rd_page];
        tefl_pkg::CMD_TEMP_PEAK:     st_next.rd_data = temp_peak[rd_page];
        tefl_pkg::CMD_TEMP_MIN:      st_next.rd_data = temp_min[rd_page];
        default:                     st_next.rd_err  = 1'b1;
      endcase
    end

    // Block read walks the RAM log byte by byte
    if (blk_start)
      st_next.blk_idx = 8'h00; // RULE_20
    else if (blk_next)
    begin
      st_next.blk_ack  = 1'b1;
      st_next.blk_data = log_mem[st_reg.blk_idx]; // RULE_20
      st_next.blk_last = (st_reg.blk_idx == tefl_pkg::LOG_LAST_BYTE);
      if (st_reg.blk_idx != tefl_pkg::LOG_LAST_BYTE)
        st_next.blk_idx = st_reg.blk_idx + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg       <= '0;
      st_reg.state <= TEFL_BOOT;
    end
    else
      st_reg <= st_next;
  end

  // Log buffer storage
  always_ff @(posedge clk_sys)
  begin
    if (mem_we)
      log_mem[mem_waddr] <= mem_wdata;
  end

  // Outputs
  assign rd_data    = st_reg.rd_data;
  assign rd_ack     = st_reg.rd_ack;
  assign rd_err     = st_reg.rd_err;
  assign blk_data   = st_reg.blk_data;
  assign blk_ack    = st_reg.blk_ack;
  assign blk_last   = st_reg.blk_last;
  assign nvm_req    = st_reg.nvm_req;
  assign nvm_we     = st_reg.nvm_we;
  assign nvm_addr   = st_reg.nvm_addr;
  assign nvm_wdata  = st_reg.nvm_wdata;
  assign log_status = {6'h00, st_reg.stat_ram, st_reg.stat_eeprom}; // RULE_19
  assign busy       = (st_reg.state != TEFL_IDLE);

endmodule : tefl_top

// ===== logic/tefl_pkg.sv
// Constants, types and helpers shared by the telemetry extremes and fault log block
// Contract
// RULE_01: Sense voltage is unsigned magnitude, 0.025*2^-13 V/LSB
// RULE_02: Input peak tracks maximum, reloads 0x7C00
// RULE_03: Output voltage peak tracks maximum, reloads 0xF800
// RULE_04: Current peak tracks maximum, reloads 0x7C00
// RULE_05: Temperature peak tracks maximum, reloads 0x7C00
// RULE_06: Input minimum tracks minimum, reloads 0x7BFF
// RULE_07: Output voltage minimum tracks minimum, reloads 0xFFFF
// RULE_08: Voltage minimum frozen while margined low ignoring faults
// RULE_09: Current minimum tracks minimum, reloads 0x7BFF
// RULE_10: Temperature minimum tracks minimum, reloads 0x7BFF
// RULE_11: RAM log buffer refreshed continuously in operation
// RULE_12: Store command 0xEA copies RAM log to NVM
// RULE_13: Fault copies RAM log to NVM, then locks
// RULE_14: Restore 0xEB reloads RAM, locked until read
// RULE_15: Clear 0xEC erases log region, re-enables transfers
// RULE_16: Host checks RAM-locked bit zero before clear
// RULE_17: Bit 0 set by store, cleared by clear
// RULE_18: Bit 1 set by restore, cleared by read
// RULE_19: Status bits 7..2 read as zero
// RULE_20: Log served as unpaged block read 0xEE
// RULE_21: Status 0xED read byte; commands are send-byte
// RULE_22: Stored bit survives resets until clear
// RULE_23: Tracker replaced only when new result beyond it
package tefl_pkg;

  // Command codes
  localparam logic [7:0] CMD_CLEAR_FAULTS  = 8'h03;
  localparam logic [7:0] CMD_LOG_STORE     = 8'hEA;
  localparam logic [7:0] CMD_LOG_RESTORE   = 8'hEB;
  localparam logic [7:0] CMD_LOG_CLEAR     = 8'hEC;
  localparam logic [7:0] CMD_LOG_STATUS    = 8'hED;
  localparam logic [7:0] CMD_LOG_BLOCK     = 8'hEE;
  localparam logic [7:0] CMD_VIN_PEAK      = 8'hDE;
  localparam logic [7:0] CMD_VOUT_PEAK     = 8'hDD;
  localparam logic [7:0] CMD_IOUT_PEAK     = 8'hD7;
  localparam logic [7:0] CMD_TEMP_PEAK     = 8'hDF;
  localparam logic [7:0] CMD_VIN_MIN       = 8'hFC;
  localparam logic [7:0] CMD_VOUT_MIN      = 8'hFB;
  localparam logic [7:0] CMD_IOUT_MIN      = 8'hD8;
  localparam logic [7:0] CMD_TEMP_MIN      = 8'hFD;
  localparam logic [7:0] CMD_SENSE_VOLTAGE = 8'hFA;

  // Tracker reload values
  localparam logic [15:0] RST_L11_PEAK  = 16'h7C00;
  localparam logic [15:0] RST_L11_MIN   = 16'h7BFF;
  localparam logic [15:0] RST_VOUT_PEAK = 16'hF800;
  localparam logic [15:0] RST_VOUT_MIN  = 16'hFFFF;

  // Status register fields
  localparam int STAT_EEPROM_BIT = 0;
  localparam int STAT_RAM_BIT    = 1;

  // Log buffer layout
  localparam logic [7:0] LOG_LAST_BYTE  = 8'hFE;
  localparam logic [7:0] NVM_FLAG_ADDR  = 8'hFF;
  localparam logic [7:0] NVM_ERASED     = 8'h00;
  localparam logic [7:0] NVM_FLAG_SET   = 8'h01;
  localparam logic [6:0] PRE_LAST_BYTE  = 7'h46;
  localparam logic [6:0] PRE_TIME_BYTE  = 7'h01;
  localparam logic [6:0] PRE_WORD_BYTE  = 7'h07;
  localparam logic [6:0] PRE_STAT_BYTE  = 7'h3B;
  localparam logic [7:0] LOOP_BASE      = 8'h47;
  localparam logic [7:0] LOOP_LAST_POS  = 8'hA6;

  // ADC result kinds
  typedef enum logic [2:0] {
    TEFL_ADC_VIN   = 3'h0,
    TEFL_ADC_VOUT  = 3'h1,
    TEFL_ADC_IOUT  = 3'h2,
    TEFL_ADC_TEMP1 = 3'h3,
    TEFL_ADC_TEMP2 = 3'h4,
    TEFL_ADC_SENSE = 3'h5
  } tefl_adc_kind_t;

  // Turns a linear 11-bit word into a plain signed fixed-point value for comparison
  function automatic logic signed [47:0] l11_value(input logic [15:0] w);
    logic signed [4:0]  e;
    logic signed [47:0] m;
    e = signed'(w[15:11]);
    m = 48'(signed'(w[10:0]));
    return m <<< (int'(e) + 16);
  endfunction : l11_value

endpackage : tefl_pkg

// ===== logic/tefl_tracker.sv
// Peak and minimum tracker for one telemetry quantity
`timescale 1ns/10ps
module tefl_tracker #(
  parameter bit          IS_L11   = 1'b1,
  parameter logic [15:0] RST_PEAK = tefl_pkg::RST_L11_PEAK,
  parameter logic [15:0] RST_MIN  = tefl_pkg::RST_L11_MIN
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Control
  input  wire logic        clear,
  input  wire logic        upd,
  input  wire logic        min_freeze,
  input  wire logic [15:0] value,
  // Extremes
  output logic      [15:0] peak,
  output logic      [15:0] min
);

  typedef struct packed {
    logic [15:0] peak;
    logic [15:0] min;
  } tefl_trk_state_t;

  tefl_trk_state_t st_reg;
  tefl_trk_state_t st_next;
  logic            above;
  logic            below;

  // Compare in the word's own number format
  always_comb
  begin
    if (IS_L11)
    begin
      above = tefl_pkg::l11_value(value) > tefl_pkg::l11_value(st_reg.peak);
      below = tefl_pkg::l11_value(value) < tefl_pkg::l11_value(st_reg.min);
    end
    else
    begin
      above = value > st_reg.peak;
      below = value < st_reg.min;
    end
  end

  // Reload on clear, otherwise replace only when the new result is beyond
  always_comb
  begin
    st_next = st_reg;
    if (clear)
    begin
      st_next.peak = RST_PEAK; // RULE_02
      st_next.min  = RST_MIN;  // RULE_06
    end
    else if (upd)
    begin
      if (above)
        st_next.peak = value; // RULE_23
      if (below && !min_freeze) // RULE_08
        st_next.min = value; // RULE_23
    end
  end

  // Power-on values are the reload values
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg.peak <= RST_PEAK;
      st_reg.min  <= RST_MIN;
    end
    else
      st_reg <= st_next;
  end

  assign peak = st_reg.peak;
  assign min  = st_reg.min;

endmodule : tefl_tracker

// ===== sim/tefl_nvm_model.sv
// Behavioural non-volatile log memory answering the block's access port
`timescale 1ns/10ps
module tefl_nvm_model (
  // Clock
  input  wire logic       clk_sys,
  // Access port
  input  wire logic       nvm_req,
  input  wire logic       nvm_we,
  input  wire logic [7:0] nvm_addr,
  input  wire logic [7:0] nvm_wdata,
  input  wire logic [1:0] dly,
  output logic            nvm_ack,
  output logic      [7:0] nvm_rdata
);
  logic [7:0] mem [256];
  logic [1:0] cnt = 2'h0;

  // Erased at power-up only, so contents outlive design resets
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'h00;
    nvm_ack = 1'b0;
    nvm_rdata = 8'h00;
  end

  // Answers after dly extra cycles; read data toggles outside the ack cycle
  always @(posedge clk_sys)
  begin
    nvm_ack <= 1'b0;
    nvm_rdata <= ~nvm_rdata;
    if (nvm_req && !nvm_ack)
    begin
      cnt <= cnt + 2'h1;
      if (cnt == dly)
      begin
        cnt <= 2'h0;
        nvm_ack <= 1'b1;
        nvm_rdata <= mem[nvm_addr];
        if (nvm_we)
          mem[nvm_addr] <= nvm_wdata;
      end
    end
  end
endmodule : tefl_nvm_model

// ===== sim/tefl_assertions.sv
// Port assertions for the telemetry extremes and fault log block
`timescale 1ns/10ps
module tefl_assertions (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_n,
  // Host side
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic        rd_req,
  input wire logic [7:0]  rd_code,
  input wire logic [15:0] rd_data,
  input wire logic        rd_ack,
  input wire logic        rd_err,
  input wire logic        blk_next,
  input wire logic        blk_done,
  input wire logic        blk_ack,
  // Memory side and status
  input wire logic        nvm_req,
  input wire logic        nvm_ack,
  input wire logic [7:0]  nvm_addr,
  input wire logic [7:0]  log_status,
  input wire logic        busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Request followed by its answer
  sequence s_rd;
    rd_req ##1 rd_ack;
  endsequence
  sequence s_blk;
    blk_next ##1 blk_ack;
  endsequence

  a_rsvd_zero: assert property (log_status[7:2] == 6'h00)
    else $error("reserved status bits set");
  a_rd_answer: assert property (rd_req |-> s_rd)
    else $error("read not answered");
  a_rd_unknown: assert property (rd_req && rd_code == 8'h00 |=> rd_err && rd_data == 16'h0000)
    else $error("unknown code not refused");
  a_blk_answer: assert property (blk_next |-> s_blk)
    else $error("block byte not answered");
  a_store_start: assert property (cmd_valid && cmd_code == 8'hEA && !busy && !log_status[0]
    |-> ##[1:2] busy)
    else $error("store did not start");
  a_nvm_hold: assert property (nvm_req && !nvm_ack |=> nvm_req && $stable(nvm_addr))
    else $error("memory request dropped");
  a_stored_keep: assert property (log_status[0] && !busy && !cmd_valid |=> log_status[0])
    else $error("stored bit lost");
  a_lock_keep: assert property (log_status[1] && !blk_done |=> log_status[1])
    else $error("ram lock lost");
endmodule : tefl_assertions

// ===== sim/tb_tefl_top.sv
// Self-checking testbench for the telemetry extremes and fault log block
`timescale 1ns/10ps
module tb_tefl_top;
  logic        clk_sys = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, rd_req = 1'b0;
  logic        blk_start = 1'b0, blk_next = 1'b0, blk_done = 1'b0, adc_valid = 1'b0;
  logic        fault_off = 1'b0, rd_ack, rd_err, blk_ack, blk_last, nvm_req, nvm_we;
  logic        nvm_ack, busy;
  logic [7:0]  cmd_code = 8'h00, rd_code = 8'h00, blk_data, nvm_addr, nvm_wdata;
  logic [7:0]  nvm_rdata, log_status;
  logic [1:0]  rd_page = 2'h0, adc_chan = 2'h0, dly = 2'h2;
  logic [2:0]  adc_kind = 3'h0;
  logic [15:0] adc_data = 16'h0000, rd_data;
  logic [3:0]  margin_low_ignore = 4'h0;
  logic [40:0] share_time = 41'h0;
  logic [95:0] chan_status = 96'h0;
  int          bad_count = 0, samples_checked = 0, n;

  tefl_top i_dut (.*);
  tefl_nvm_model i_nvm (.*);

  // Clock
  always #25 clk_sys = ~clk_sys;

  task automatic tick;
    @(posedge clk_sys);
    #5;
  endtask : tick

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic wait_idle;
    tick;
    tick;
    for (n = 0; busy !== 1'b0 && n < 4000; n++)
      tick;
  endtask : wait_idle

  task automatic rd(input logic [7:0] code, input logic [1:0] pg, input logic [15:0] exp);
    rd_req = 1'b1;
    rd_code = code;
    rd_page = pg;
    tick;
    rd_req = 1'b0;
    tick;
    check(rd_data, exp);
  endtask : rd

  task automatic cmd(input logic [7:0] code);
    cmd_valid = 1'b1;
    cmd_code = code;
    tick;
    cmd_valid = 1'b0;
    wait_idle;
  endtask : cmd

  task automatic adc(input logic [2:0] k, input logic [1:0] ch, input logic [15:0] d);
    adc_valid = 1'b1;
    adc_kind = k;
    adc_chan = ch;
    adc_data = d;
    tick;
    adc_valid = 1'b0;
    tick;
  endtask : adc

  task automatic t_reset_values;
    rd(8'hDE, 2'h0, 16'h7C00);
    rd(8'hDD, 2'h3, 16'hF800);
    rd(8'hD7, 2'h1, 16'h7C00);
    rd(8'hDF, 2'h2, 16'h7C00);
    rd(8'hFC, 2'h0, 16'h7BFF);
    rd(8'hFB, 2'h3, 16'hFFFF);
    rd(8'hD8, 2'h1, 16'h7BFF);
    rd(8'hFD, 2'h2, 16'h7BFF);
  endtask : t_reset_values

  task automatic t_track;
    adc(3'h0, 2'h0, 16'h0010);
    adc(3'h0, 2'h0, 16'h0008);
    rd(8'hDE, 2'h0, 16'h0010);
    rd(8'hFC, 2'h0, 16'h0008);
    adc(3'h1, 2'h1, 16'hF900);
    margin_low_ignore = 4'h2;
    adc(3'h1, 2'h1, 16'hF880);
    rd(8'hFB, 2'h1, 16'hF900);
    rd(8'hDD, 2'h1, 16'hF900);
    margin_low_ignore = 4'h0;
    adc(3'h1, 2'h1, 16'hF880);
    rd(8'hFB, 2'h1, 16'hF880);
    adc(3'h2, 2'h2, 16'h0005);
    adc(3'h2, 2'h2, 16'h0003);
    rd(8'hD7, 2'h2, 16'h0005);
    rd(8'hD8, 2'h2, 16'h0003);
    adc(3'h3, 2'h2, 16'hFFFE);
    rd(8'hDF, 2'h2, 16'hFFFE);
    rd(8'hFD, 2'h2, 16'hFFFE);
    adc(3'h5, 2'h2, 16'hFE06);
    rd(8'hFA, 2'h2, 16'h01FA);
    rd(8'h00, 2'h0, 16'h0000);
    check(16'(rd_err), 16'h0001);
    cmd(8'h03);
    t_reset_values;
  endtask : t_track

  task automatic t_log;
    cmd(8'hEA);
    rd(8'hED, 2'h0, 16'h0001);
    check(16'(i_nvm.mem[8'hFF]), 16'h0001);
    dly = 2'h0;
    rst_n = 1'b0;
    tick;
    rst_n = 1'b1;
    wait_idle;
    rd(8'hED, 2'h0, 16'h0001);
    cmd(8'hEB);
    rd(8'hED, 2'h0, 16'h0003);
    blk_start = 1'b1;
    tick;
    blk_start = 1'b0;
    n = 0;
    do
    begin
      blk_next = 1'b1;
      tick;
      blk_next = 1'b0;
      n++;
      tick;
    end while (blk_last !== 1'b1 && n < 300);
    check(16'(n), 16'h00FF);
    blk_done = 1'b1;
    tick;
    blk_done = 1'b0;
    rd(8'hED, 2'h0, 16'h0001);
    cmd(8'hEC);
    rd(8'hED, 2'h0, 16'h0000);
    check(16'(i_nvm.mem[8'h10]), 16'h0000);
    fault_off = 1'b1;
    tick;
    fault_off = 1'b0;
    wait_idle;
    rd(8'hED, 2'h0, 16'h0001);
  endtask : t_log

  // Watchdog against a hang
  initial
  begin
    #1000000;
    bad_count++;
    end_of_test;
  end

  // Main sequence
  initial
  begin
    tick;
    tick;
    rst_n = 1'b1;
    wait_idle;
    rd(8'hED, 2'h0, 16'h0000);
    t_reset_values;
    t_track;
    t_log;
    end_of_test;
  end
endmodule : tb_tefl_top

bind tefl_top tefl_assertions i_chk (.*);
